/* File: design/mcg_clock_gen.sv */
// Oscillator selection, CPU clock division and clock output
// ****************************************************
// Overview of operation
// R1 - Pick one of four oscillator sources
// R2 - CPU clock comes from programmable divider
// R3 - Machine cycle spans two CPU clocks
// R4 - Peripheral clock is half CPU clock
// R5 - RC oscillator nominally 7.373 MHz
// R6 - Crystal offers low, medium, high ranges
// R7 - Clock output only without crystal use
// R8 - Clock output needs enable bit six
// R9 - Clock output toggles at half CPU
// R10 - Trim loaded only by power-on reset
// R11 - Software preserves other trim bits
// R12 - Software may disable output before idle
// R13 - Bit seven selects RC as source
// R14 - Low six bits tune RC frequency
// R15 - Divider divides by twice N, N=0 bypass
// R16 - Wake-up delay counts oscillator cycles first
// R17 - Source or divisor changes never glitch
// ****************************************************
`timescale 1ns/1ps
module mcg_clock_gen #(
	parameter int WAKE_WAIT = mcg_pkg::WAKE_MIN_CYCLES
) (
	input  wire logic       clock,           // 100 MHz system clock
	input  wire logic       reset,           // Any reset, synchronous
	input  wire logic       power_on_reset,  // Power-on only, synchronous
	input  wire logic [3:0] osc_inputs,      // Raw source clocks by code
	input  wire logic [1:0] config_source,   // Programmed source select
	input  wire logic [1:0] config_range,    // Programmed crystal range
	input  wire logic       rtc_on_crystal,  // RTC runs from crystal
	input  wire logic [5:0] factory_trim,    // Stored calibration value
	input  wire logic [7:0] divisor_in,      // CPU clock divisor N, level
	input  wire logic [7:0] sfr_addr,        // Register address
	input  wire logic [7:0] sfr_wdata,       // Register write data
	input  wire logic       sfr_write,       // Write strobe
	output logic [7:0]      sfr_rdata_ff,    // Read data, next cycle
	output logic            cpu_tick_ff,     // CPU clock tick
	output logic            machine_tick_ff, // Machine cycle tick
	output logic            periph_tick_ff,  // Peripheral clock tick
	output logic            clock_ready_ff,  // Wake-up delay done
	output logic [5:0]      rc_trim,         // RC oscillator tuning
	output logic [1:0]      crystal_range_ff, // Crystal amplifier range
	output logic            crystal_output_pin_ff, // Pin output value
	output logic            crystal_output_oe_ff   // Pin output enable
);

	// ****************************************************
	// Registers
	// ****************************************************
	logic [7:0]        trim_ff;
	logic [1:0]        source_ff;
	logic [1:0]        sel_ff;
	logic [3:0]        sync1_ff;
	logic [3:0]        sync2_ff;
	logic [3:0]        prev_ff;
	logic [12:0]       wake_cnt_ff;
	mcg_pkg::mcg_wake_e wake_ff;
	logic              phase_ff;
	logic              divider_tick;
	logic [1:0]        nxt_sel;
	logic              osc_tick;
	logic              out_allowed;
	logic              out_enable;
	logic [7:0]        divisor_in_ff;
	logic [7:0]        cpu_clock_divisor;

	// Oscillator cycles to wait before the fixed delay
	function automatic logic [12:0] wake_osc(input logic [1:0] src);
		return (src == mcg_pkg::SRC_CRYSTAL) ?
			13'(mcg_pkg::WAKE_CRYSTAL) : 13'(mcg_pkg::WAKE_OTHER);
	endfunction : wake_osc

	// ****************************************************
	// Trim register
	// ****************************************************
	// Of the resets only power-on reset touches it, so calibration survives other resets
	always_ff @(posedge clock) begin
		if (power_on_reset)
			trim_ff <= {mcg_pkg::CTRL_RESET, factory_trim};  // R10
		else if (sfr_write && sfr_addr == mcg_pkg::TRIM_ADDR)
			trim_ff <= sfr_wdata;                             // R11
	end

	assign rc_trim = trim_ff[mcg_pkg::TRIM_VALUE_MSB:0]; // R14 R5

	// Read returns the whole register so software can modify in place
	always_ff @(posedge clock) begin
		if (reset || power_on_reset)
			sfr_rdata_ff <= 8'h00;
		else if (sfr_addr == mcg_pkg::TRIM_ADDR)
			sfr_rdata_ff <= trim_ff;                          // R11
		else
			sfr_rdata_ff <= 8'h00;
	end

	// ****************************************************
	// Configuration capture
	// ****************************************************
	// Programmed straps are taken while reset is held
	always_ff @(posedge clock) begin
		if (reset || power_on_reset) begin
			source_ff        <= config_source;                // R1
			crystal_range_ff <= config_range;                 // R6
		end
	end

	// ****************************************************
	// Source selection
	// ****************************************************
	// Every source passes two flops before its edge is looked at
	always_ff @(posedge clock) begin
		if (reset || power_on_reset) begin
			sync1_ff <= 4'hF; // High, so an idle-high source
			sync2_ff <= 4'hF; // gives no false edge after reset
			prev_ff  <= 4'hF;
		end else begin
			sync1_ff <= osc_inputs;
			sync2_ff <= sync1_ff;
			prev_ff  <= sync2_ff;
		end
	end

	always_comb begin
		nxt_sel = trim_ff[mcg_pkg::RC_SELECT_BIT] ?
			mcg_pkg::SRC_RC : source_ff;                      // R13 R1
	end

	always_ff @(posedge clock) begin
		if (reset || power_on_reset)
			sel_ff <= config_source;
		else
			sel_ff <= nxt_sel;
	end

	assign osc_tick = sync2_ff[sel_ff] && !prev_ff[sel_ff];

	// ****************************************************
	// Wake-up delay
	// ****************************************************
	// Oscillator cycles first, then a fixed settling time
	always_ff @(posedge clock) begin
		if (reset || power_on_reset) begin
			wake_ff     <= mcg_pkg::ST_OSC;
			wake_cnt_ff <= '0;
		end else begin
			case (wake_ff)
			mcg_pkg::ST_OSC: begin
				if (osc_tick) begin
					if (wake_cnt_ff == wake_osc(sel_ff) - 13'd1) begin
						wake_ff     <= mcg_pkg::ST_TIME;         // R16
						wake_cnt_ff <= '0;
					end else
						wake_cnt_ff <= wake_cnt_ff + 13'd1;
				end
			end
			mcg_pkg::ST_TIME: begin
				if (wake_cnt_ff == 13'(WAKE_WAIT - 1))
					wake_ff <= mcg_pkg::ST_RUN;                  // R16
				else
					wake_cnt_ff <= wake_cnt_ff + 13'd1;
			end
			mcg_pkg::ST_RUN:
				wake_ff <= mcg_pkg::ST_RUN;
			default:
				wake_ff <= mcg_pkg::ST_OSC;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (reset || power_on_reset)
			clock_ready_ff <= 1'b0;
		else
			clock_ready_ff <= (wake_ff == mcg_pkg::ST_RUN);
	end

	// ****************************************************
	// CPU clock divider
	// ****************************************************
	// A source change restarts the period, trading one slow period for
	// the certainty of no truncated pulse
	mcg_divider #(
		.DIV_W (8)
	) u_divider (
		.clock       (clock),
		.reset       (reset || power_on_reset),
		.run         (wake_ff == mcg_pkg::ST_RUN && nxt_sel == sel_ff),
		.osc_tick    (osc_tick),
		.divisor     (cpu_clock_divisor),
		.cpu_tick_ff (divider_tick)
	);

	// Divisor comes from the CPU clock divisor register elsewhere
	assign cpu_clock_divisor = divisor_in_ff;
	always_ff @(posedge clock) begin
		if (reset || power_on_reset)
			divisor_in_ff <= 8'h00;
		else
			divisor_in_ff <= divisor_in;
	end

	// ****************************************************
	// Derived ticks
	// ****************************************************
	always_ff @(posedge clock) begin
		if (reset || power_on_reset) begin
			phase_ff        <= 1'b0;
			cpu_tick_ff     <= 1'b0;
			machine_tick_ff <= 1'b0;
			periph_tick_ff  <= 1'b0;
		end else begin
			phase_ff        <= divider_tick ? !phase_ff : phase_ff;
			cpu_tick_ff     <= divider_tick;                  // R2
			machine_tick_ff <= divider_tick && phase_ff;      // R3
			periph_tick_ff  <= divider_tick && phase_ff;      // R4
		end
	end

	// ****************************************************
	// Clock output pin
	// ****************************************************
	assign out_allowed = sel_ff != mcg_pkg::SRC_CRYSTAL && !rtc_on_crystal;
	assign out_enable  = trim_ff[mcg_pkg::CLOCK_OUT_EN_BIT] && out_allowed;

	// Toggles once per CPU clock, so the pin runs at half that rate
	always_ff @(posedge clock) begin
		if (reset || power_on_reset || !out_enable) begin
			crystal_output_pin_ff <= 1'b0;                    // R7 R8
			crystal_output_oe_ff  <= 1'b0;
		end else begin
			crystal_output_oe_ff <= 1'b1;                     // R8
			if (divider_tick)
				crystal_output_pin_ff <= !crystal_output_pin_ff; // R9
		end
	end

	// ****************************************************
	// Checks
	// ****************************************************
	a_trim_por: assert property (@(posedge clock) // R10
		power_on_reset |=> trim_ff == {mcg_pkg::CTRL_RESET, factory_trim})
		else $error("trim not loaded at power-on");
	a_trim_kept: assert property (@(posedge clock) // R10
		reset && !power_on_reset && !sfr_write |=> $stable(trim_ff))
		else $error("trim changed by non power-on reset");
	a_rc_select: assert property (@(posedge clock) // R13
		disable iff (reset || power_on_reset)
		trim_ff[mcg_pkg::RC_SELECT_BIT] |=> sel_ff == mcg_pkg::SRC_RC)
		else $error("rc select ignored");
	a_out_crystal: assert property (@(posedge clock) // R7
		disable iff (reset || power_on_reset)
		sel_ff == mcg_pkg::SRC_CRYSTAL |=> !crystal_output_oe_ff)
		else $error("clock output while crystal in use");
	a_out_enable: assert property (@(posedge clock) // R8
		disable iff (reset || power_on_reset)
		!trim_ff[mcg_pkg::CLOCK_OUT_EN_BIT] |=> !crystal_output_oe_ff)
		else $error("clock output without enable bit");
	a_out_toggle: assert property (@(posedge clock) // R9
		disable iff (reset || power_on_reset)
		crystal_output_oe_ff && $past(crystal_output_oe_ff) && cpu_tick_ff
		|-> crystal_output_pin_ff != $past(crystal_output_pin_ff))
		else $error("clock output missed a toggle");
	a_machine_half: assert property (@(posedge clock) // R3
		disable iff (reset || power_on_reset)
		machine_tick_ff |-> cpu_tick_ff)
		else $error("machine tick without cpu tick");
	a_wake_hold: assert property (@(posedge clock) // R16
		disable iff (reset || power_on_reset)
		wake_ff != mcg_pkg::ST_RUN |=> !cpu_tick_ff)
		else $error("cpu clock ran during wake-up delay");
	a_read_trim: assert property (@(posedge clock) // R11
		disable iff (reset || power_on_reset)
		sfr_addr == mcg_pkg::TRIM_ADDR && !sfr_write
		|=> sfr_rdata_ff == $past(trim_ff))
		else $error("trim read wrong");

	c_ready: cover property (@(posedge clock) clock_ready_ff);
	c_output: cover property (@(posedge clock) crystal_output_oe_ff);
	c_rc_switch: cover property (@(posedge clock)
		$rose(trim_ff[mcg_pkg::RC_SELECT_BIT]));
	c_machine: cover property (@(posedge clock) machine_tick_ff);

endmodule : mcg_clock_gen

/* File: design/mcg_divider.sv */
// CPU clock divider producing one tick per CPU clock period
`timescale 1ns/1ps
module mcg_divider #(
	parameter int DIV_W = 8
) (
	input  wire logic             clock,     // System clock
	input  wire logic             reset,     // Synchronous, active high
	input  wire logic             run,       // Low restarts the period
	input  wire logic             osc_tick,  // One pulse per oscillator cycle
	input  wire logic [DIV_W-1:0] divisor,   // Requested divisor N
	output logic                  cpu_tick_ff // One pulse per CPU cycle
);

	logic [DIV_W:0]   count_ff;
	logic [DIV_W-1:0] div_ff;

	// Last count of a period: 2N-1, or 0 when N is zero
	function automatic logic [DIV_W:0] last_count(
		input logic [DIV_W-1:0] n
	);
		if (n == '0)
			return '0;
		return {n, 1'b0} - {{DIV_W{1'b0}}, 1'b1};
	endfunction : last_count

	// *************************************************
	// Period counter
	// *************************************************
	// Divisor is only adopted at a period end or restart so no short pulse appears
	always_ff @(posedge clock) begin
		if (reset || !run) begin
			count_ff    <= '0;
			div_ff      <= divisor;                       // R17
			cpu_tick_ff <= 1'b0;
		end else if (osc_tick && count_ff == last_count(div_ff)) begin
			count_ff    <= '0;                             // R15
			div_ff      <= divisor;                        // R17
			cpu_tick_ff <= 1'b1;                           // R2
		end else begin
			count_ff    <= osc_tick ? count_ff + 1'b1 : count_ff;
			cpu_tick_ff <= 1'b0;
		end
	end

	a_tick_spacing: assert property (@(posedge clock) disable iff (reset)
		cpu_tick_ff && div_ff != '0 |=> !cpu_tick_ff) // R15
		else $error("cpu tick repeated with nonzero divisor");

endmodule : mcg_divider

/* File: design/mcg_pkg.sv */
// Constants shared by the clock generation block
package mcg_pkg;

	// ****************************************************
	// Register map and trim register fields
	// ****************************************************
	localparam logic [7:0] TRIM_ADDR      = 8'h96;
	localparam int         RC_SELECT_BIT  = 7;
	localparam int         CLOCK_OUT_EN_BIT = 6;
	localparam int         TRIM_VALUE_MSB = 5;
	localparam logic [1:0] CTRL_RESET     = 2'h0; // Bits 7:6 after power-on

	// ****************************************************
	// Oscillator sources and crystal ranges
	// ****************************************************
	localparam logic [1:0] SRC_CRYSTAL  = 2'h0;
	localparam logic [1:0] SRC_EXTERNAL = 2'h1;
	localparam logic [1:0] SRC_RC       = 2'h2;
	localparam logic [1:0] SRC_WATCHDOG = 2'h3;
	localparam logic [1:0] RANGE_LOW    = 2'h0; // 20 kHz to 100 kHz
	localparam logic [1:0] RANGE_MEDIUM = 2'h1; // 100 kHz to 4 MHz
	localparam logic [1:0] RANGE_HIGH   = 2'h2; // 4 MHz to 12 MHz
	localparam int RANGE_LOW_MIN_KHZ    = 20;
	localparam int RANGE_MEDIUM_MIN_KHZ = 100;
	localparam int RANGE_HIGH_MIN_KHZ   = 4000;
	localparam int RANGE_HIGH_MAX_KHZ   = 12000;
	localparam int RC_NOMINAL_KHZ       = 7373;

	// ****************************************************
	// Timing
	// ****************************************************
	localparam int CLOCK_MHZ       = 100;
	localparam int WAKE_CRYSTAL    = 992; // Oscillator cycles
	localparam int WAKE_OTHER      = 224; // Oscillator cycles
	localparam int WAKE_MIN_US     = 60;
	localparam int WAKE_MIN_CYCLES = WAKE_MIN_US * CLOCK_MHZ;

	// Start-up sequence, one-hot
	typedef enum logic [2:0] {
		ST_OSC  = 3'b001,
		ST_TIME = 3'b010,
		ST_RUN  = 3'b100
	} mcg_wake_e;

endpackage : mcg_pkg

/* File: tb/mcg_clock_gen_bench.sv */
// Self-checking bench for the clock generation block
`timescale 1ns/1ps
module mcg_clock_gen_bench;
	logic       clock;
	logic       reset;
	logic       power_on_reset;
	logic [3:0] osc_inputs;
	logic [1:0] config_source;
	logic [1:0] config_range;
	logic       rtc_on_crystal;
	logic [5:0] factory_trim;
	logic [7:0] divisor_in;
	logic [7:0] sfr_addr;
	logic [7:0] sfr_wdata;
	logic       sfr_write;
	logic [7:0] sfr_rdata_ff;
	logic       cpu_tick_ff;
	logic       machine_tick_ff;
	logic       periph_tick_ff;
	logic       clock_ready_ff;
	logic [5:0] rc_trim;
	logic [1:0] crystal_range_ff;
	logic       pin_ff;
	logic       oe_ff;
	int         n_fail = 0;
	int         samples_checked = 0;
	int         cycles = 0;
	int         n_cpu, n_mach, n_per, n_tog;
	logic [7:0] v;

	// ****************************************************
	// Design under test, short wake wait
	// ****************************************************
	mcg_clock_gen #(.WAKE_WAIT(20)) mcg_clock_gen_i (
		.clock(clock), .reset(reset), .power_on_reset(power_on_reset),
		.osc_inputs(osc_inputs), .config_source(config_source),
		.config_range(config_range), .rtc_on_crystal(rtc_on_crystal),
		.factory_trim(factory_trim), .divisor_in(divisor_in),
		.sfr_addr(sfr_addr),
		.sfr_wdata(sfr_wdata), .sfr_write(sfr_write),
		.sfr_rdata_ff(sfr_rdata_ff), .cpu_tick_ff(cpu_tick_ff),
		.machine_tick_ff(machine_tick_ff), .periph_tick_ff(periph_tick_ff),
		.clock_ready_ff(clock_ready_ff), .rc_trim(rc_trim),
		.crystal_range_ff(crystal_range_ff),
		.crystal_output_pin_ff(pin_ff), .crystal_output_oe_ff(oe_ff));

	// ****************************************************
	// Clock, source oscillators and hang guard
	// ****************************************************
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	// Sources run slower than the system clock so the synchroniser sees them
	always @(negedge clock) begin
		cycles <= cycles + 1;
		if (cycles % 4 == 3) osc_inputs <= ~osc_inputs;
	end
	// Two RC wake-ups and one crystal wake-up fit well inside this ceiling
	always @(posedge clock) begin
		if (cycles == 40000) begin
			n_fail++;
			close_out();
		end
	end

	// ****************************************************
	// Shared tasks
	// ****************************************************
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic close_out();
		if (n_fail == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : close_out
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_write = 1'b1;
		@(negedge clock);
		sfr_write = 1'b0;
	endtask : wr
	// Read data is registered, so it is taken one cycle later
	task automatic rd(input logic [7:0] a);
		@(negedge clock);
		sfr_addr = a;
		@(negedge clock);
		v = sfr_rdata_ff;
	endtask : rd
	task automatic do_reset(input logic por);
		@(negedge clock);
		reset = 1'b1;
		power_on_reset = por;
		repeat (8) @(negedge clock);
		reset = 1'b0;
		power_on_reset = 1'b0;
	endtask : do_reset
	task automatic wait_ready(input int early, input int limit);
		repeat (early) @(negedge clock);
		check(8'(clock_ready_ff), 8'h0);
		for (int i = 0; i < limit && clock_ready_ff !== 1'b1; i++)
			@(negedge clock);
		check(8'(clock_ready_ff), 8'h1);
	endtask : wait_ready
	// Counts ticks and pin toggles over a window
	task automatic count(input int n);
		logic prev;
		n_cpu = 0; n_mach = 0; n_per = 0; n_tog = 0;
		prev = pin_ff;
		repeat (n) begin
			@(negedge clock);
			n_cpu += int'(cpu_tick_ff === 1'b1);
			n_mach += int'(machine_tick_ff === 1'b1);
			n_per += int'(periph_tick_ff === 1'b1);
			n_tog += int'(pin_ff !== prev);
			prev = pin_ff;
		end
		check(8'(n_cpu > 0), 8'h1);
		check(8'(n_mach * 2 >= n_cpu - 1 && n_mach * 2 <= n_cpu + 1), 8'h1);
		check(8'(n_per), 8'(n_mach));
	endtask : count

	// ****************************************************
	// Scenarios
	// ****************************************************
	task automatic t_power_on();
		do_reset(1'b1);
		check(8'(rc_trim), 8'h2A);
		check(8'(crystal_range_ff), 8'(mcg_pkg::RANGE_HIGH));
		rd(mcg_pkg::TRIM_ADDR);
		check(v, 8'h2A);
		rd(8'h95);
		check(v, 8'h00);
		wait_ready(1000, 3000);
	endtask : t_power_on
	task automatic t_clock_out();
		count(1200);
		check(8'(oe_ff), 8'h0);
		wr(mcg_pkg::TRIM_ADDR, 8'h6A);
		repeat (3) @(negedge clock);
		check(8'(oe_ff), 8'h1);
		count(1200);
		check(8'(n_tog >= n_cpu - 1 && n_tog <= n_cpu + 1), 8'h1);
		rtc_on_crystal = 1'b1;
		repeat (3) @(negedge clock);
		check(8'(oe_ff), 8'h0);
		rtc_on_crystal = 1'b0;
		wr(mcg_pkg::TRIM_ADDR, 8'h2A);
		repeat (3) @(negedge clock);
		check(8'(oe_ff), 8'h0);
	endtask : t_clock_out
	// Source edges come every 8 clocks, so N=2 ticks once per 32 clocks
	task automatic t_divide();
		divisor_in = 8'h02;
		repeat (64) @(negedge clock);
		count(1280);
		check(8'(n_cpu), 8'h28);
		divisor_in = 8'h00;
		repeat (64) @(negedge clock);
		count(1280);
		check(8'(n_cpu), 8'hA0);
	endtask : t_divide
	// A plain reset must leave the whole trim byte alone
	task automatic t_trim_keep();
		wr(mcg_pkg::TRIM_ADDR, 8'hC5);
		rd(mcg_pkg::TRIM_ADDR);
		check(v, 8'hC5);
		check(8'(rc_trim), 8'h05);
		count(1200);
		do_reset(1'b0);
		rd(mcg_pkg::TRIM_ADDR);
		check(v, 8'hC5);
		check(8'(rc_trim), 8'h05);
		wait_ready(1000, 3000);
	endtask : t_trim_keep
	// With the crystal in use the output never drives
	task automatic t_crystal();
		config_source = mcg_pkg::SRC_CRYSTAL;
		config_range = mcg_pkg::RANGE_LOW;
		factory_trim = 6'h15;
		do_reset(1'b1);
		check(8'(crystal_range_ff), 8'(mcg_pkg::RANGE_LOW));
		rd(mcg_pkg::TRIM_ADDR);
		check(v, 8'h15);
		wait_ready(6000, 4000);
		wr(mcg_pkg::TRIM_ADDR, 8'h55);
		repeat (3) @(negedge clock);
		check(8'(oe_ff), 8'h0);
		count(1200);
		wr(mcg_pkg::TRIM_ADDR, 8'hD5);
		repeat (3) @(negedge clock);
		check(8'(oe_ff), 8'h1);
		count(1200);
	endtask : t_crystal

	// ****************************************************
	// Main sequence
	// ****************************************************
	initial begin
		reset = 1'b1;
		power_on_reset = 1'b1;
		osc_inputs = 4'h0;
		config_source = mcg_pkg::SRC_RC;
		config_range = mcg_pkg::RANGE_HIGH;
		rtc_on_crystal = 1'b0;
		factory_trim = 6'h2A;
		divisor_in = 8'h00;
		sfr_addr = 8'h00;
		sfr_wdata = 8'h00;
		sfr_write = 1'b0;
		t_power_on();
		t_clock_out();
		t_divide();
		t_trim_keep();
		t_crystal();
		close_out();
	end
endmodule : mcg_clock_gen_bench
